// >>> logic/ffx_defines.svh
// timing and size constants for the fifo host controller
`ifndef FFX_DEFINES_SVH
`define FFX_DEFINES_SVH
`define FFX_CLK_PERIOD_NS      100
`define FFX_DEPTH              11'h400
`define FFX_PTR_W              10
`define FFX_DATA_W             9
`define FFX_STROBE_LOW_NS      50
`define FFX_STROBE_LOW_CYC     ((`FFX_STROBE_LOW_NS + `FFX_CLK_PERIOD_NS - 1) / `FFX_CLK_PERIOD_NS)
`define FFX_RECOVERY_NS        15
`define FFX_RECOVERY_CYC       ((`FFX_RECOVERY_NS + `FFX_CLK_PERIOD_NS - 1) / `FFX_CLK_PERIOD_NS)
`define FFX_FLAG_SETTLE_NS     65
`define FFX_FLAG_SETTLE_CYC    ((`FFX_FLAG_SETTLE_NS + `FFX_CLK_PERIOD_NS - 1) / `FFX_CLK_PERIOD_NS)
`define FFX_REPLAY_CYCLE_NS    65
`define FFX_REPLAY_CYCLE_CYC   ((`FFX_REPLAY_CYCLE_NS + `FFX_CLK_PERIOD_NS - 1) / `FFX_CLK_PERIOD_NS)
`define FFX_RESET_LOW_NS       65
`define FFX_RESET_LOW_CYC      ((`FFX_RESET_LOW_NS + `FFX_CLK_PERIOD_NS - 1) / `FFX_CLK_PERIOD_NS)
`define FFX_CNT_W              4
`endif

// >>> logic/ffx_host.sv
// host controller driving a clockless 1024x9 fifo through its pins
`timescale 1ns/1ns
`default_nettype none
`include "ffx_defines.svh"

module ffx_host (
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       clk_en,
  input  wire logic       depth_mode,
  input  wire logic       first_in_chain,
  input  wire logic       cmd_valid,
  input  wire ffx_pkg::ffx_op_t cmd_op,
  input  wire logic [8:0] cmd_wdata,
  input  wire logic       nothing_stored_flag_n,
  input  wire logic       no_room_flag_n,
  input  wire logic       half_level_flag_n,
  input  wire logic [8:0] fifo_q,
  output logic            master_clear_n,
  output logic            write_n,
  output logic            read_n,
  output logic            first_load_or_replay_n,
  output logic [8:0]      fifo_d,
  output logic            fifo_d_oe_n,
  output logic            cmd_busy,
  output logic            cmd_refused,
  output logic [8:0]      rd_data,
  output logic            rd_valid,
  output logic            empty_seen_n,
  output logic            full_seen_n,
  output logic            half_seen_n
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  ffx_pkg::ffx_state_reg_t s_r;
  ffx_pkg::ffx_state_reg_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rvalid = 1'b0;
    s_nxt.refused = 1'b0;
    // pins pass two flops; fifo_q first stage is read only by second
    s_nxt.empty_s = {s_r.empty_s[0], nothing_stored_flag_n};
    s_nxt.full_s = {s_r.full_s[0], no_room_flag_n};
    s_nxt.half_s = {s_r.half_s[0], half_level_flag_n};
    s_nxt.q_s1 = fifo_q;
    s_nxt.q_s2 = s_r.q_s1;
    case (s_r.state)
      ffx_pkg::FFX_IDLE:
      begin
        // flags are sampled only while no strobe is settling
        s_nxt.empty_n = s_r.empty_s[1];
        s_nxt.full_n = s_r.full_s[1];
        s_nxt.half_n = depth_mode ? 1'b1 : s_r.half_s[1];
        if (cmd_valid)
        begin
          s_nxt.op = cmd_op;
          s_nxt.cnt = 4'h0;
          case (cmd_op)
            ffx_pkg::FFX_OP_CLEAR:
            begin
              s_nxt.state = ffx_pkg::FFX_CLEAR;
              s_nxt.clear_n = 1'b0;
              s_nxt.busy = 1'b1;
              s_nxt.first_load_or_replay_n_n = ~(depth_mode & first_in_chain);
              s_nxt.wr_cnt = 11'h000;
            end
            ffx_pkg::FFX_OP_WRITE:
              if (s_r.full_s[1])
              begin
                s_nxt.state = ffx_pkg::FFX_STROBE;
                s_nxt.wr_n = 1'b0;
                s_nxt.dout = cmd_wdata;
                s_nxt.dout_oe_n = 1'b0;
                s_nxt.busy = 1'b1;
                // saturating count of writes since clear
                if (s_r.wr_cnt <= `FFX_DEPTH)
                  s_nxt.wr_cnt = s_r.wr_cnt + 11'h001;
              end
              else
                s_nxt.refused = 1'b1;
            ffx_pkg::FFX_OP_READ:
              if (s_r.empty_s[1])
              begin
                s_nxt.state = ffx_pkg::FFX_STROBE;
                s_nxt.rd_n = 1'b0;
                s_nxt.busy = 1'b1;
              end
              else
                s_nxt.refused = 1'b1;
            default:
              if (!depth_mode && s_r.wr_cnt <= `FFX_DEPTH)
              begin
                s_nxt.state = ffx_pkg::FFX_REPLAY;
                s_nxt.first_load_or_replay_n_n = 1'b0;
                s_nxt.busy = 1'b1;
              end
              else
                s_nxt.refused = 1'b1;
          endcase
        end
      end
      ffx_pkg::FFX_CLEAR:
      begin
        s_nxt.cnt = s_r.cnt + 4'h1;
        if (s_r.cnt >= 4'(`FFX_RESET_LOW_CYC - 1))
        begin
          s_nxt.clear_n = 1'b1;
          // first-load level is kept after clear in depth mode
          s_nxt.first_load_or_replay_n_n = s_r.first_load_or_replay_n_n;
          s_nxt.state = ffx_pkg::FFX_SETTLE;
          s_nxt.cnt = 4'h0;
        end
      end
      ffx_pkg::FFX_STROBE:
      begin
        s_nxt.cnt = s_r.cnt + 4'h1;
        if (s_r.cnt >= 4'(`FFX_STROBE_LOW_CYC - 1))
        begin
          s_nxt.wr_n = 1'b1;
          s_nxt.rd_n = 1'b1;
          s_nxt.state = ffx_pkg::FFX_RECOVER;
          s_nxt.cnt = 4'h0;
        end
      end
      ffx_pkg::FFX_RECOVER:
      begin
        s_nxt.dout_oe_n = 1'b1;
        s_nxt.cnt = s_r.cnt + 4'h1;
        if (s_r.cnt >= 4'(`FFX_RECOVERY_CYC - 1))
        begin
          s_nxt.state = ffx_pkg::FFX_SETTLE;
          s_nxt.cnt = 4'h0;
        end
      end
      ffx_pkg::FFX_REPLAY:
      begin
        s_nxt.cnt = s_r.cnt + 4'h1;
        if (s_r.cnt >= 4'(`FFX_REPLAY_CYCLE_CYC - 1))
        begin
          s_nxt.first_load_or_replay_n_n = 1'b1;
          s_nxt.state = ffx_pkg::FFX_SETTLE;
          s_nxt.cnt = 4'h0;
        end
      end
      ffx_pkg::FFX_SETTLE:
      begin
        // wait out flag settling plus synchroniser latency
        s_nxt.cnt = s_r.cnt + 4'h1;
        // read word reaches second data flop one cycle after strobe
        if (s_r.op == ffx_pkg::FFX_OP_READ && s_r.cnt == 4'h0)
        begin
          s_nxt.rdata = s_r.q_s2;
          s_nxt.rvalid = 1'b1;
        end
        if (s_r.cnt >= 4'(`FFX_FLAG_SETTLE_CYC + 2))
        begin
          s_nxt.state = ffx_pkg::FFX_IDLE;
          s_nxt.busy = 1'b0;
          s_nxt.cnt = 4'h0;
        end
      end
      default:
        s_nxt.state = ffx_pkg::FFX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_r <= '0;
      s_r.state <= ffx_pkg::FFX_IDLE;
      s_r.clear_n <= 1'b1;
      s_r.wr_n <= 1'b1;
      s_r.rd_n <= 1'b1;
      s_r.first_load_or_replay_n_n <= 1'b1;
      s_r.dout_oe_n <= 1'b1;
      s_r.full_n <= 1'b1;
      s_r.half_n <= 1'b1;
    end
    else if (clk_en)
      s_r <= s_nxt;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign master_clear_n = s_r.clear_n;
  assign write_n = s_r.wr_n;
  assign read_n = s_r.rd_n;
  assign first_load_or_replay_n = s_r.first_load_or_replay_n_n;
  assign fifo_d = s_r.dout;
  assign fifo_d_oe_n = s_r.dout_oe_n;
  assign cmd_busy = s_r.busy;
  assign cmd_refused = s_r.refused;
  assign rd_data = s_r.rdata;
  assign rd_valid = s_r.rvalid;
  assign empty_seen_n = s_r.empty_n;
  assign full_seen_n = s_r.full_n;
  assign half_seen_n = s_r.half_n;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  no_strobe_replay_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !s_r.first_load_or_replay_n_n && s_r.clear_n && s_r.op == ffx_pkg::FFX_OP_REPLAY |-> s_r.rd_n && s_r.wr_n)
    else $error("strobe during replay");
  write_needs_room_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $fell(s_r.wr_n) |-> $past(s_r.full_s[1]))
    else $error("write launched while full");
  read_needs_data_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $fell(s_r.rd_n) |-> $past(s_r.empty_s[1]))
    else $error("read launched while empty");
  replay_single_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $fell(s_r.first_load_or_replay_n_n) && s_r.clear_n |-> !$past(depth_mode))
    else $error("replay in depth mode");
  clear_strobes_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !s_r.clear_n |-> s_r.rd_n && s_r.wr_n)
    else $error("strobe during clear");
  first_load_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(s_r.clear_n) |-> s_r.first_load_or_replay_n_n == $past(s_r.first_load_or_replay_n_n) && s_r.first_load_or_replay_n_n == !$past(depth_mode && first_in_chain, 2))
    else $error("first load changed at clear end");
  half_depth_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    depth_mode && s_r.state == ffx_pkg::FFX_IDLE && $past(s_r.state == ffx_pkg::FFX_IDLE) && $past(depth_mode)
    |-> s_r.half_n)
    else $error("half flag reported in depth mode");
  settle_wait_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(s_r.wr_n) |-> s_r.busy [*3])
    else $error("controller left busy too soon");

endmodule
`default_nettype wire

// >>> logic/ffx_pkg.sv
// types for the fifo host controller
`default_nettype none
package ffx_pkg;
  typedef enum logic [2:0] {
    FFX_IDLE,
    FFX_CLEAR,
    FFX_STROBE,
    FFX_RECOVER,
    FFX_REPLAY,
    FFX_SETTLE
  } ffx_state_t;

  typedef enum logic [1:0] {
    FFX_OP_WRITE,
    FFX_OP_READ,
    FFX_OP_REPLAY,
    FFX_OP_CLEAR
  } ffx_op_t;

  typedef struct packed {
    ffx_state_t state;
    ffx_op_t    op;
    logic [3:0] cnt;
    logic       clear_n;
    logic       wr_n;
    logic       rd_n;
    logic       first_load_or_replay_n_n;
    logic [8:0] dout;
    logic       dout_oe_n;
    logic [8:0] rdata;
    logic       rvalid;
    logic       busy;
    logic       refused;
    logic       empty_n;
    logic       full_n;
    logic       half_n;
    logic [1:0] empty_s;
    logic [1:0] full_s;
    logic [1:0] half_s;
    logic [8:0] q_s1;
    logic [8:0] q_s2;
    logic [10:0] wr_cnt;
  } ffx_state_reg_t;
endpackage
`default_nettype wire

// >>> tb/ffx_fifo_model.sv
// behavioural model of the 1024x9 fifo seen by the host controller
`timescale 1ns/1ns
`default_nettype none
module ffx_fifo_model (
  input  wire logic       master_clear_n,
  input  wire logic       write_n,
  input  wire logic       read_n,
  input  wire logic       first_load_or_replay_n,
  input  wire logic [8:0] fifo_d,
  input  wire logic       fifo_d_oe_n,
  output logic            nothing_stored_flag_n,
  output logic            no_room_flag_n,
  output logic            half_level_flag_n,
  output logic [8:0]      fifo_q
);
  logic [8:0] mem [0:1023];
  logic [9:0] wp, rp;
  logic       ok_w, ok_r;
  int         cnt;
  initial
  begin
    wp = 0; rp = 0; cnt = 0; ok_w = 0; ok_r = 0; fifo_q = 9'h0AA;
  end
  always @*
  begin
    nothing_stored_flag_n = (cnt != 0);
    no_room_flag_n = (cnt != 1024);
    half_level_flag_n = (cnt < 513) || !master_clear_n;
  end
  always @(negedge master_clear_n)
  begin
    wp = 0; rp = 0; cnt = 0;
  end
  always @(negedge write_n) ok_w = master_clear_n && (cnt < 1024);
  // undriven data bus stores garbage
  always @(posedge write_n)
    if (ok_w)
    begin
      mem[wp] = fifo_d_oe_n ? ~fifo_d : fifo_d;
      wp = wp + 10'h001;
      cnt = cnt + 1;
    end
  always @(negedge read_n)
  begin
    ok_r = master_clear_n && (cnt != 0);
    if (ok_r) fifo_q = mem[rp];
  end
  always @(posedge read_n)
  begin
    fifo_q = ~fifo_q;
    if (ok_r)
    begin
      rp = rp + 10'h001;
      cnt = cnt - 1;
    end
  end
  always @(negedge first_load_or_replay_n)
    if (master_clear_n)
    begin
      rp = 0;
      cnt = int'(wp);
    end
endmodule
`default_nettype wire

// >>> tb/ffx_host_tb.sv
// self-checking bench for the fifo host controller
`timescale 1ns/1ns
`default_nettype none
module ffx_host_tb;
  logic             sys_clk, nrst, depth_mode, cmd_valid, cmd_busy, cmd_refused, rd_valid, got_ref, got_rv, fic;
  logic             mc_n, wr_n, rd_n, fl_n, oe_n, es_n, fs_n, hs_n, ef_n, ff_n, hf_n;
  logic [8:0]       cmd_wdata, fifo_d, fifo_q, rd_data, got_d;
  logic [8:0]       mem [0:1023];
  logic [9:0]       wp, rp;
  logic [31:0]      seed;
  int               cnt, i, error_cnt, checks_done, wsc;
  ffx_pkg::ffx_op_t cmd_op;
  ffx_host dut (.sys_clk(sys_clk), .nrst(nrst), .clk_en(1'b1), .depth_mode(depth_mode), .first_in_chain(fic),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_wdata(cmd_wdata), .nothing_stored_flag_n(ef_n),
    .no_room_flag_n(ff_n), .half_level_flag_n(hf_n), .fifo_q(fifo_q), .master_clear_n(mc_n), .write_n(wr_n),
    .read_n(rd_n), .first_load_or_replay_n(fl_n), .fifo_d(fifo_d), .fifo_d_oe_n(oe_n), .cmd_busy(cmd_busy),
    .cmd_refused(cmd_refused), .rd_data(rd_data), .rd_valid(rd_valid), .empty_seen_n(es_n),
    .full_seen_n(fs_n), .half_seen_n(hs_n));
  ffx_fifo_model fifo (.master_clear_n(mc_n), .write_n(wr_n), .read_n(rd_n), .first_load_or_replay_n(fl_n),
    .fifo_d(fifo_d), .fifo_d_oe_n(oe_n), .nothing_stored_flag_n(ef_n), .no_room_flag_n(ff_n),
    .half_level_flag_n(hf_n), .fifo_q(fifo_q));
  initial
  begin
    sys_clk = 0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    if (rd_valid === 1'b1) got_rv <= 1;
    if (rd_valid === 1'b1) got_d <= rd_data;
    if (cmd_refused === 1'b1) got_ref <= 1;
  end
  function logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // one command, expectation from the bench's own fifo image
  task op(input ffx_pkg::ffx_op_t o, input logic [8:0] d);
    logic       ref_e, rd_e;
    logic [8:0] dat_e;
    int         k;
    ref_e = (o == ffx_pkg::FFX_OP_WRITE && cnt == 1024) || (o == ffx_pkg::FFX_OP_READ && cnt == 0)
      || (o == ffx_pkg::FFX_OP_REPLAY && (depth_mode || wsc > 1024));
    rd_e = (o == ffx_pkg::FFX_OP_READ) && !ref_e;
    dat_e = mem[rp];
    if (!ref_e)
      case (o)
        ffx_pkg::FFX_OP_WRITE: begin mem[wp] = d; wp++; cnt++; wsc++; end
        ffx_pkg::FFX_OP_READ: begin rp++; cnt--; end
        ffx_pkg::FFX_OP_REPLAY: begin rp = 0; cnt = int'(wp); end
        default: begin wp = 0; rp = 0; cnt = 0; wsc = 0; end
      endcase
    got_ref = 0;
    got_rv = 0;
    @(posedge sys_clk);
    cmd_valid <= 1;
    cmd_op <= o;
    cmd_wdata <= d;
    @(posedge sys_clk);
    cmd_valid <= 0;
    for (k = 0; k < 40 && (k < 3 || cmd_busy !== 1'b0); k++) @(posedge sys_clk);
    chk("busy", cmd_busy, 0);
    repeat (4) @(posedge sys_clk);
    chk("refused", got_ref, ref_e);
    chk("rvalid", got_rv, rd_e);
    if (rd_e) chk("data", got_d, dat_e);
    chk("empty", es_n, cnt != 0);
    chk("full", fs_n, cnt != 1024);
    chk("half", hs_n, depth_mode || cnt < 513);
  endtask
  initial
  begin
    nrst = 0; depth_mode = 0; cmd_valid = 0; cmd_op = ffx_pkg::FFX_OP_CLEAR; cmd_wdata = 0;
    error_cnt = 0; checks_done = 0; seed = 32'h13B2; wp = 0; rp = 0; cnt = 0;
    got_ref = 0; got_rv = 0; got_d = 0; fic = 1; wsc = 0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1;
    op(ffx_pkg::FFX_OP_CLEAR, 0);
    op(ffx_pkg::FFX_OP_READ, 0);
    $display("test clear done");
    for (i = 0; i < 600; i++)
    begin
      seed = lfsr(seed);
      op(ffx_pkg::FFX_OP_WRITE, seed[8:0]);
    end
    for (i = 0; i < 5; i++) op(ffx_pkg::FFX_OP_READ, 0);
    op(ffx_pkg::FFX_OP_REPLAY, 0);
    for (i = 0; i < 5; i++) op(ffx_pkg::FFX_OP_READ, 0);
    $display("test replay done");
    depth_mode <= 1;
    @(posedge sys_clk);
    op(ffx_pkg::FFX_OP_REPLAY, 0);
    op(ffx_pkg::FFX_OP_CLEAR, 0);
    chk("first load", fl_n, 9'h000);
    fic <= 0;
    @(posedge sys_clk);
    op(ffx_pkg::FFX_OP_CLEAR, 0);
    chk("later load", fl_n, 9'h001);
    depth_mode <= 0;
    fic <= 1;
    @(posedge sys_clk);
    op(ffx_pkg::FFX_OP_CLEAR, 0);
    $display("test depth done");
    while (cnt < 1024)
    begin
      seed = lfsr(seed);
      op(ffx_pkg::FFX_OP_WRITE, seed[8:0]);
    end
    op(ffx_pkg::FFX_OP_WRITE, 9'h155);
    op(ffx_pkg::FFX_OP_READ, 0);
    op(ffx_pkg::FFX_OP_WRITE, 9'h0F0);
    for (i = 0; i < 300; i++)
    begin
      seed = lfsr(seed);
      op(seed[0] ? ffx_pkg::FFX_OP_READ : ffx_pkg::FFX_OP_WRITE, seed[9:1]);
    end
    $display("test full done");
    op(ffx_pkg::FFX_OP_REPLAY, 0);
    while (cnt > 0) op(ffx_pkg::FFX_OP_READ, 0);
    op(ffx_pkg::FFX_OP_READ, 0);
    $display("test drain done");
    print_verdict;
  end
  initial
  begin
    repeat (90000) @(posedge sys_clk);
    error_cnt++;
    print_verdict;
  end
endmodule
`default_nettype wire
